// [rtl/conv_common.sv]
/*
 * Shared constants for the converter control block, plus the two-flop
 * level synchroniser that the control block instantiates.
 * Assumes a 10 MHz core clock and pin inputs asynchronous to it.
 */
// Operation
// RULE_01 - byte-select low puts result bits 5 and 4 on lowest pins, else ground; code puts result bits 7 to 4 on the four lowest pins
// RULE_02 - parallel pins float while chip select high or read/convert low
// RULE_03 - bit clock pin direction follows clock-source select; data tracks that clock
// RULE_04 - source high: host clocks data; low: convert sends previous result with own clock
// RULE_05 - internal mode emits exactly 12 clock pulses per conversion, then holds low
// RULE_06 - serial result uses number format chosen by code-format select
// RULE_07 - format select high gives straight binary, low gives two's complement
// RULE_08 - external mode shifts tag levels after 12 bits while frame stays open
// RULE_09 - internal mode data stable across both edges of generated clock
// RULE_10 - internal mode idles serial output at tag level captured at start
// RULE_11 - external mode forwards tag input to serial output after fixed delay
// RULE_12 - byte-select low shows 8 upper bits, high shows low bits
// RULE_13 - with chip select low, read/convert falling edge holds sample and converts
// RULE_14 - internal mode read/convert start also transmits previous result
// RULE_15 - chip select and read/convert ORed; chip select fall converts if read/convert low
// RULE_16 - internal mode chip-select start also transmits previous result
// RULE_17 - busy low from conversion start until outputs hold the new result
// RULE_18 - convert commands while busy low are ignored
// RULE_19 - power-down high inhibits conversions and keeps previous result
// RULE_20 - reference shutdown high disables internal reference; host supplies external one
package conv_pkg;
    localparam int          RES_W           = 12;
    localparam int          BYTE_W          = 8;
    localparam int          CLK_PERIOD_NS   = 100;
    localparam int          CONV_TIME_NS    = 8000;
    localparam int          CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          QTR_CYCLES      = 1;
    localparam int          SER_BITS        = 12;
    localparam int          SYNC_IN_W       = 7;
    localparam logic [11:0] RESULT_RST      = 12'h000;
    localparam logic [11:0] SIGN_FLIP       = 12'h800;
    localparam logic [3:0]  LOW_PAD         = 4'h0;
    localparam logic [1:0]  PH_SET          = 2'h0;
    localparam logic [1:0]  PH_RISE         = 2'h1;
    localparam logic [1:0]  PH_FALL         = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b100
    } conv_state_e;
endpackage : conv_pkg

`timescale 1ns/1ps
module level_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            meta_r <= '0;
            q_o    <= '0;
        end
        else
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule : level_sync

// [rtl/sar_conv_ctrl.sv]
/*
 * Conversion control and result output port of a 12-bit sampling
 * converter: start logic, busy, parallel byte port, serial port with
 * internal or host-supplied bit clock and tag pass-through.
 * Assumes sar_result_i is the straight-binary core result, stable while
 * a conversion runs; all other inputs are asynchronous pins.
 */
`timescale 1ns/1ps
module sar_conv_ctrl
    import conv_pkg::*;
#(
    parameter int CONV_CNT = CONV_CYCLES
) (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              chip_sel_n_i,
    input  wire logic              read_conv_i,
    input  wire logic              byte_sel_i,
    input  wire logic              clock_source_select_i,
    input  wire logic              code_format_select_i,
    input  wire logic              power_down_in_i,
    input  wire logic              reference_shutdown_i,
    input  wire logic              tag_i,
    input  wire logic [RES_W-1:0]  sar_result_i,
    input  wire logic              serial_bit_clock_i,
    output logic                   serial_bit_clock_o,
    output logic                   serial_bit_clock_oe_o,
    output logic                   serial_result_out_o,
    output logic [BYTE_W-1:0]      par_data_o,
    output logic                   par_data_oe_o,
    output logic                   busy_n_o,
    output logic                   sample_hold_o,
    output logic                   int_ref_en_o
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic cs_n_s;
    logic rc_s;
    logic byte_s;
    logic src_s;
    logic fmt_s;
    logic pd_s;
    logic tag_s;
    logic ref_sd_s;

    level_sync #(.W(SYNC_IN_W)) u_sync_core (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .d_i       ({chip_sel_n_i, read_conv_i, byte_sel_i, clock_source_select_i,
                     code_format_select_i, power_down_in_i, tag_i}),
        .q_o       ({cs_n_s, rc_s, byte_s, src_s, fmt_s, pd_s, tag_s})
    );

    // only the reference enable reads this one
    level_sync #(.W(1)) u_sync_ref (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .d_i       (reference_shutdown_i),
        .q_o       (ref_sd_s)
    );

    // ------------------------------------------------------------
    // start detection
    // ------------------------------------------------------------
    conv_state_e       state_r;
    logic              comb_n_r;
    logic              start;
    logic              comb_n;
    logic [RES_W-1:0]  result_r;
    logic [15:0]       conv_cnt_r;
    logic              int_mode_r;
    logic              tag_cap_r;
    logic [RES_W-1:0]  tx_sh_r;
    logic [3:0]        tx_left_r;
    logic [1:0]        phase_r;
    logic [7:0]        qtr_cnt_r;
    logic              int_serial_result_out_r;

    assign comb_n = cs_n_s | rc_s;                                     // RULE_15
    // either input may be the one that falls; both read as one level
    // a command while not idle is dropped, never queued
    assign start  = comb_n_r & ~comb_n & (state_r == ST_IDLE) & ~pd_s; // RULE_13 RULE_15 RULE_18 RULE_19

    // resets low: synchronisers read zero at release, which is no fresh command
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            comb_n_r <= 1'b0;
        else
            comb_n_r <= comb_n;
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r    <= ST_IDLE;
            conv_cnt_r <= 16'h0000;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state_r    <= ST_CONV;
                        conv_cnt_r <= 16'(CONV_CNT);
                    end
                end
                ST_CONV:
                begin
                    if (conv_cnt_r != 16'h0000)
                        conv_cnt_r <= conv_cnt_r - 16'h0001;
                    // internal mode holds busy until the word has gone out
                    else if (!int_mode_r || tx_left_r == 4'h0)
                        state_r <= ST_DONE;
                end
                ST_DONE:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            result_r  <= RESULT_RST;
        end
        else if (state_r == ST_CONV && conv_cnt_r == 16'h0000 && (!int_mode_r || tx_left_r == 4'h0))
        begin
            // format fixed at store time so both ports agree
            result_r  <= fmt_s ? sar_result_i : (sar_result_i ^ SIGN_FLIP); // RULE_06 RULE_07
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            busy_n_o      <= 1'b1;
            sample_hold_o <= 1'b0;
        end
        else
        begin
            busy_n_o      <= ~(start | (state_r == ST_CONV));           // RULE_17
            sample_hold_o <= start | (state_r == ST_CONV);              // RULE_13
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            int_ref_en_o <= 1'b1;
        else
            int_ref_en_o <= ~ref_sd_s;                                  // RULE_20
    end

    // ------------------------------------------------------------
    // parallel byte port
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            par_data_o    <= 8'h00;
            par_data_oe_o <= 1'b0;
        end
        else
        begin
            par_data_oe_o <= ~cs_n_s & rc_s;                            // RULE_02
            if (!byte_s)
                par_data_o <= result_r[RES_W-1:RES_W-BYTE_W];           // RULE_12 RULE_01
            else
                par_data_o <= {result_r[RES_W-BYTE_W-1:0], LOW_PAD};    // RULE_12 RULE_01
        end
    end

    // ------------------------------------------------------------
    // internal-clock serial transmitter
    // ------------------------------------------------------------
    // each bit is four quarters: data set, clock high, clock high, clock low
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            int_mode_r  <= 1'b0;
            tag_cap_r   <= 1'b0;
            tx_sh_r     <= RESULT_RST;
            tx_left_r   <= 4'h0;
            phase_r     <= PH_SET;
            qtr_cnt_r   <= 8'h00;
            int_serial_result_out_r <= 1'b0;
        end
        else if (start)
        begin
            int_mode_r <= ~src_s;                                       // RULE_04
            tag_cap_r  <= tag_s;                                        // RULE_10
            tx_sh_r    <= result_r;                                     // RULE_14 RULE_16
            tx_left_r  <= src_s ? 4'h0 : 4'(SER_BITS);                  // RULE_05
            phase_r    <= PH_SET;
            qtr_cnt_r  <= 8'h00;
        end
        else if (tx_left_r != 4'h0)
        begin
            if (qtr_cnt_r != 8'(QTR_CYCLES - 1))
                qtr_cnt_r <= qtr_cnt_r + 8'h01;
            else
            begin
                qtr_cnt_r <= 8'h00;
                phase_r   <= phase_r + 2'h1;
                // data moves only in the low quarter before the rising edge
                if (phase_r == PH_SET)
                begin
                    int_serial_result_out_r <= tx_sh_r[RES_W-1];                    // RULE_09
                    tx_sh_r     <= {tx_sh_r[RES_W-2:0], 1'b0};
                end
                if (phase_r == PH_FALL)
                    tx_left_r <= tx_left_r - 4'h1;
            end
        end
        else if (phase_r == PH_SET)
            int_serial_result_out_r <= tag_cap_r;                                   // RULE_10
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            serial_bit_clock_o    <= 1'b0;
            serial_bit_clock_oe_o <= 1'b0;
        end
        else
        begin
            serial_bit_clock_oe_o <= ~src_s;                            // RULE_03
            serial_bit_clock_o    <= (tx_left_r != 4'h0) && (phase_r == PH_RISE || phase_r == 2'h2); // RULE_05
        end
    end

    // ------------------------------------------------------------
    // host-clocked serial port (link domain)
    // ------------------------------------------------------------
    logic              lk_frame_rst_n;
    logic              lk_open;
    logic              lk_tag;
    logic [RES_W-1:0]  lk_sh_r;
    logic [3:0]        lk_cnt_r;
    logic              lk_serial_result_out_r;

    // a closed frame clears the open flag at once, so a host that stops
    // its clock between frames still starts the next one from the top bit
    assign lk_frame_rst_n = reset_n_i & ~chip_sel_n_i & read_conv_i;

    level_sync #(.W(1)) u_sync_open (
        .clk_i     (serial_bit_clock_i),
        .reset_n_i (lk_frame_rst_n),
        .d_i       (1'b1),
        .q_o       (lk_open)
    );

    // tag reaches the pin two link edges after it is sampled
    level_sync #(.W(1)) u_sync_tag (
        .clk_i     (serial_bit_clock_i),
        .reset_n_i (reset_n_i),
        .d_i       (tag_i),
        .q_o       (lk_tag)
    );

    always_ff @(posedge serial_bit_clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            lk_sh_r    <= RESULT_RST;
            lk_cnt_r   <= 4'h0;
            lk_serial_result_out_r <= 1'b0;
        end
        else if (!lk_open)
        begin
            // word only moves at end of conversion; frames open after busy rises
            lk_sh_r  <= result_r;
            lk_cnt_r <= 4'h0;
        end
        else if (lk_cnt_r != 4'(SER_BITS))
        begin
            lk_serial_result_out_r <= lk_sh_r[RES_W-1];                             // RULE_04 RULE_03
            lk_sh_r    <= {lk_sh_r[RES_W-2:0], 1'b0};
            lk_cnt_r   <= lk_cnt_r + 4'h1;
        end
        else
            lk_serial_result_out_r <= lk_tag;                                       // RULE_08 RULE_11
    end

    // source select is a strap; the mux picks whichever domain owns the pin
    assign serial_result_out_o = src_s ? lk_serial_result_out_r : int_serial_result_out_r;      // RULE_03
endmodule : sar_conv_ctrl

// [sim/sar_conv_ctrl_properties.sv]
/* Port checker for the converter control block, bound to each instance.
   Assumes pin inputs are held at least four core cycles between changes. */
`timescale 1ns/1ps
module sar_conv_ctrl_properties
    import conv_pkg::*;
#(
    parameter int CONV_CNT = CONV_CYCLES
) (
    input wire logic              clk_i,
    input wire logic              reset_n_i,
    input wire logic              chip_sel_n_i,
    input wire logic              read_conv_i,
    input wire logic              byte_sel_i,
    input wire logic              clock_source_select_i,
    input wire logic              power_down_in_i,
    input wire logic              reference_shutdown_i,
    input wire logic              serial_bit_clock_o,
    input wire logic              serial_bit_clock_oe_o,
    input wire logic              serial_result_out_o,
    input wire logic [BYTE_W-1:0] par_data_o,
    input wire logic              par_data_oe_o,
    input wire logic              busy_n_o,
    input wire logic              sample_hold_o,
    input wire logic              int_ref_en_o
);
    logic [7:0] low_cnt_r;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // length of the current busy-low run
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            low_cnt_r <= 8'h00;
        else
            low_cnt_r <= busy_n_o ? 8'h00 : low_cnt_r + 8'h01;
    end
    AST_PAR_ON: assert property ((!chip_sel_n_i && read_conv_i)[*4] |-> par_data_oe_o)
        else $error("parallel bus idle in read");
    AST_PAR_OFF: assert property ((chip_sel_n_i || !read_conv_i)[*4] |-> !par_data_oe_o)
        else $error("parallel bus driven outside read");
    AST_LOW_PAD: assert property (byte_sel_i[*4] |-> par_data_o[3:0] == 4'h0)
        else $error("low pins not grounded");
    AST_CLK_IN: assert property (clock_source_select_i[*4] |-> !serial_bit_clock_oe_o)
        else $error("bit clock driven in host mode");
    AST_CLK_OUT: assert property (!clock_source_select_i[*4] |-> serial_bit_clock_oe_o)
        else $error("bit clock not driven in device mode");
    AST_CLK_IDLE: assert property (busy_n_o |-> !serial_bit_clock_o)
        else $error("bit clock not low between conversions");
    AST_BIT_HOLD: assert property (serial_bit_clock_oe_o && $rose(serial_bit_clock_o) |-> $stable(serial_result_out_o)[*3])
        else $error("serial bit moved during clock pulse");
    AST_START: assert property (busy_n_o && !power_down_in_i && $fell(chip_sel_n_i | read_conv_i) |-> ##[2:5] (!busy_n_o && sample_hold_o))
        else $error("convert command not taken");
    AST_BUSY_MIN: assert property ($rose(busy_n_o) |-> low_cnt_r >= CONV_CNT)
        else $error("busy released early");
    AST_BUSY_MAX: assert property ($fell(busy_n_o) |-> ##[5:120] busy_n_o)
        else $error("busy stuck low");
    AST_PD_HOLD: assert property (power_down_in_i[*4] ##0 busy_n_o |=> busy_n_o)
        else $error("conversion during power down");
    AST_REF: assert property ($stable(reference_shutdown_i)[*3] |-> int_ref_en_o == !reference_shutdown_i)
        else $error("reference enable wrong");
    COV_INT: cover property (serial_bit_clock_oe_o && $rose(serial_bit_clock_o));
    COV_REFUSED: cover property (!busy_n_o && $fell(read_conv_i));
    COV_PD: cover property (power_down_in_i && $fell(chip_sel_n_i | read_conv_i));
endmodule : sar_conv_ctrl_properties

bind sar_conv_ctrl sar_conv_ctrl_properties #(.CONV_CNT(CONV_CNT)) sar_conv_ctrl_properties_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .chip_sel_n_i(chip_sel_n_i), .read_conv_i(read_conv_i),
    .byte_sel_i(byte_sel_i), .clock_source_select_i(clock_source_select_i), .power_down_in_i(power_down_in_i),
    .reference_shutdown_i(reference_shutdown_i), .serial_bit_clock_o(serial_bit_clock_o),
    .serial_bit_clock_oe_o(serial_bit_clock_oe_o), .serial_result_out_o(serial_result_out_o),
    .par_data_o(par_data_o), .par_data_oe_o(par_data_oe_o), .busy_n_o(busy_n_o),
    .sample_hold_o(sample_hold_o), .int_ref_en_o(int_ref_en_o));

// [sim/host_link.sv]
/* Host end of the serial link: bursts of a 48 ns bit clock, shifting in data.
   Assumes the bench opens the frame before a burst. */
`timescale 1ns/1ps
module host_link (
    input  wire logic serial_result_out_i,
    output logic      sclk_o,
    output logic      [31:0] shift_o
);
    initial
    begin
        sclk_o = 1'b0;
        shift_o = '0;
    end
    // clock stands low outside bursts
    task automatic burst(input int n);
        repeat (n)
        begin
            #24 sclk_o = 1'b1;
            #24 sclk_o = 1'b0;
        end
    endtask : burst
    always @(posedge sclk_o) shift_o <= {shift_o[30:0], serial_result_out_i};
endmodule : host_link

// [sim/sar_conv_ctrl_bench.sv]
/* Self-checking bench for the converter control block.
   Assumes CONV_CNT of 5 and a host model on the serial pins. */
`timescale 1ns/1ps
module sar_conv_ctrl_bench;
    import conv_pkg::*;
    logic clk_i = 0, reset_n_i = 0, chip_sel_n_i = 1, read_conv_i = 1, byte_sel_i = 0, tag_i = 0;
    logic clock_source_select_i = 1, code_format_select_i = 1, power_down_in_i = 0, reference_shutdown_i = 0;
    logic [RES_W-1:0] sar_result_i = '0, last = '0, prev, ish;
    logic sclk, sclk_oe, serial_result_out, oe, busy_n, ref_en, host_clk, ok;
    logic [BYTE_W-1:0] par;
    logic [31:0] hshift;
    int errors = 0, comparisons = 0, cycles = 0, ipc = 0;
    wire sclk_pin = sclk_oe ? sclk : host_clk;
    always #50 clk_i = ~clk_i;
    sar_conv_ctrl #(.CONV_CNT(5)) sar_conv_ctrl_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .chip_sel_n_i(chip_sel_n_i), .read_conv_i(read_conv_i), .byte_sel_i(byte_sel_i),
        .clock_source_select_i(clock_source_select_i), .code_format_select_i(code_format_select_i),
        .power_down_in_i(power_down_in_i), .reference_shutdown_i(reference_shutdown_i), .tag_i(tag_i),
        .sar_result_i(sar_result_i), .serial_bit_clock_i(sclk_pin), .serial_bit_clock_o(sclk),
        .serial_bit_clock_oe_o(sclk_oe), .serial_result_out_o(serial_result_out), .par_data_o(par),
        .par_data_oe_o(oe), .busy_n_o(busy_n), .sample_hold_o(), .int_ref_en_o(ref_en));
    host_link host_link_i (.serial_result_out_i(serial_result_out), .sclk_o(host_clk), .shift_o(hshift));
    // ----------------
    // helpers
    // ----------------
    always @(posedge sclk)
    begin
        ish = {ish[10:0], serial_result_out};
        ipc++;
    end
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic wait_busy(input logic v);
        for (int k = 0; k < 300 && busy_n !== v; k++) tick(1);
        chk({11'h0, busy_n}, {11'h0, v});
    endtask : wait_busy
    function automatic logic [11:0] fmt(input logic [11:0] r, input logic f);
        return f ? r : r ^ SIGN_FLIP;
    endfunction : fmt
    // by_cs: chip select makes the falling edge; again: second command while busy
    task automatic conv(input logic by_cs, input logic again, input logic [11:0] r);
        logic f;
        f = 1'($urandom);
        sar_result_i = r;
        code_format_select_i = f;
        chip_sel_n_i = by_cs;
        read_conv_i = !by_cs;
        tick(3);
        if (by_cs) chip_sel_n_i = 0;
        else read_conv_i = 0;
        wait_busy(0);
        tag_i = !tag_i;
        if (again)
        begin
            read_conv_i = 1;
            tick(2);
            read_conv_i = 0;
            wait_busy(1);
            tick(10);
            chk({11'h0, busy_n}, 12'h1);
        end
        read_conv_i = 1;
        wait_busy(1);
        last = fmt(r, f);
    endtask : conv
    task automatic rd();
        chip_sel_n_i = 0;
        byte_sel_i = 0;
        tick(4);
        chk({oe, 3'h0, par}, {4'h8, last[11:4]});
        byte_sel_i = 1;
        tick(4);
        chk({oe, 3'h0, par}, {4'h8, last[3:0], 4'h0});
        chip_sel_n_i = 1;
        tick(4);
        chk({11'h0, oe}, 12'h0);
    endtask : rd
    // ----------------
    // tests
    // ----------------
    initial
    begin
        void'($urandom(59));
        tick(20);
        reset_n_i = 1;
        tick(3);
        conv(0, 1, 12'h800);
        rd();
        conv(1, 0, 12'h7FF);
        rd();
        repeat (6)
        begin
            conv(1'($urandom), 0, 12'($urandom));
            rd();
        end
        $display("parallel test done");
        power_down_in_i = 1;
        reference_shutdown_i = 1;
        tick(4);
        chk({11'h0, ref_en}, 12'h0);
        read_conv_i = 0;
        tick(2);
        chip_sel_n_i = 0;
        tick(20);
        chk({11'h0, busy_n}, 12'h1);
        power_down_in_i = 0;
        reference_shutdown_i = 0;
        read_conv_i = 1;
        rd();
        chk({11'h0, ref_en}, 12'h1);
        $display("power down test done");
        clock_source_select_i = 0;
        tick(4);
        repeat (3)
        begin
            prev = last;
            ipc = 0;
            conv(1'($urandom), 0, 12'($urandom));
            chk(12'(ipc), 12'h00C);
            chk(ish, prev);
            chk({11'h0, serial_result_out}, {11'h0, !tag_i});
        end
        $display("internal clock test done");
        clock_source_select_i = 1;
        conv(0, 0, 12'($urandom) & 12'hFFE);
        tag_i = 1;
        chip_sel_n_i = 1;
        tick(4);
        chip_sel_n_i = 0;
        tick(4);
        #7 host_link_i.burst(20);
        ok = 0;
        for (int k = 0; k < 8; k++) if (hshift[k+:13] === {last, 1'b1}) ok = 1;
        chk({11'h0, ok}, 12'h1);
        $display("external clock test done");
        results();
    end
endmodule : sar_conv_ctrl_bench
